// ---- logic/input_sync.sv ----
`timescale 1ns/10ps
module input_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic core_clk,
  input  wire logic reset,
  sync_if.sync_side bus
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] clean_ff;
  logic [WIDTH-1:0] agree;

  // A bit only moves once stages two and three agree, which also eats one-cycle glitches
  assign agree = ~(s2_ff ^ s3_ff);

  // Stage one feeds stage two only
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s1_ff    <= RESET_VAL;
      s2_ff    <= RESET_VAL;
      s3_ff    <= RESET_VAL;
      clean_ff <= RESET_VAL;
    end else begin
      s1_ff    <= bus.raw;
      s2_ff    <= s1_ff;
      s3_ff    <= s2_ff;
      clean_ff <= (agree & s3_ff) | (~agree & clean_ff);
    end
  end

  assign bus.clean = clean_ff;

endmodule

// ---- logic/reset_source_controller.sv ----
`timescale 1ns/10ps
module reset_source_controller
#(
  parameter int unsigned POR_CYC_LOW  = rsc_pkg::POR_CYC_LOW,
  parameter int unsigned POR_CYC_MID  = rsc_pkg::POR_CYC_MID,
  parameter int unsigned POR_CYC_HIGH = rsc_pkg::POR_CYC_HIGH
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        rst_pin_n_in,
  input  wire logic        vbat_low,
  input  wire logic [1:0]  vbat_level,
  input  wire logic        vdd_below_rst,
  input  wire logic        vdd_below_warn,
  input  wire logic        sleep_mode,
  input  wire logic        flash_wr_attempt,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata_ff,
  output logic             sys_reset_ff,
  output logic             rst_pin_out_ff,
  output logic             rst_pin_oe_ff,
  output logic             rst_pin_pullup_ff,
  output logic      [7:0]  port_latch_ff,
  output logic             port_open_drain_ff,
  output logic             port_pullup_ff,
  output logic             clk_int_sel_ff,
  output logic             wdt_en_ff,
  output logic      [3:0]  wdt_div_ff,
  output logic             fetch_start_ff,
  output logic      [15:0] fetch_addr_ff,
  output logic             regulator_en_ff,
  output logic             bat_mon_en_ff,
  output logic             vdd_mon_en_ff,
  output logic             supply_ok_ff,
  output logic             supply_warn_irq_ff
);
  import rsc_pkg::*;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  sync_if #(.WIDTH(6)) pins ();

  assign pins.raw = {vbat_level, vdd_below_warn, vdd_below_rst, vbat_low, rst_pin_n_in};

  input_sync #(
    .WIDTH     (6),
    .RESET_VAL (6'h03)  // Battery reads low until the chain has really sampled it
  ) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .bus      (pins.sync_side)
  );

  wire       pin_low_s  = ~pins.clean[0];
  wire       vbat_low_s = pins.clean[1];
  wire       vdd_low_s  = pins.clean[2];
  wire       warn_low_s = pins.clean[3];
  wire [1:0] vbat_lvl_s = pins.clean[5:4];

  // ****************************************************************
  // State
  // ****************************************************************
  rst_state_t       state_ff;
  rst_state_t       nxt_state;
  logic [DLY_W-1:0] dly_cnt_ff;
  logic [DLY_W-1:0] nxt_dly_cnt;
  logic [3:0]       hold_cnt_ff;
  logic [3:0]       nxt_hold_cnt;
  logic [4:0]       cause_ff;
  logic [4:0]       nxt_cause;
  logic [3:0]       oe_hist_ff;
  logic             flag_pin_ff;
  logic             flag_por_ff;
  logic             flag_sw_ff;
  logic             flag_flash_ff;
  logic             vdm_en_ff;
  logic             vdm_sel_ff;
  logic             warn_ie_ff;
  logic             bat_mon_off_ff;
  logic             sw_req_ff;

  // Release delay chosen from the battery level band
  function automatic logic [DLY_W-1:0] por_delay(input logic [1:0] lvl);
    logic [DLY_W-1:0] cyc;
    cyc = DLY_W'(POR_CYC_HIGH - 1);
    if (lvl == 2'h0) begin
      cyc = DLY_W'(POR_CYC_LOW - 1);
    end else if (lvl == 2'h1) begin
      cyc = DLY_W'(POR_CYC_MID - 1);
    end
    return cyc;
  endfunction

  // ****************************************************************
  // Reset sources
  // ****************************************************************
  // Our own low drive reads back for four cycles after release; mask it
  wire pin_ext_low = pin_low_s & ~(|oe_hist_ff);
  wire vdd_fail    = vdm_en_ff & vdm_sel_ff & ~sleep_mode & vdd_low_s;
  wire flash_err   = flash_wr_attempt & ~vdm_en_ff;
  wire bat_fail    = ~bat_mon_off_ff & vbat_low_s;
  wire any_src     = pin_ext_low | vdd_fail | sw_req_ff | flash_err;
  wire hold_src    = pin_ext_low | vdd_fail;
  wire in_run      = (state_ff == ST_RUN);
  wire nxt_in_rst  = (nxt_state != ST_RUN);
  wire exit_rst    = ~in_run & ~nxt_in_rst;
  wire enter_rst   = in_run & nxt_in_rst;
  wire full_por    = nxt_cause[C_POR] | nxt_cause[C_VDD];

  // Register decode
  wire sel_smc = (sfr_addr == ADDR_SUPPLY_MON_CTRL);
  wire sel_rs  = (sfr_addr == ADDR_RESET_SOURCE);
  wire sel_pum = (sfr_addr == ADDR_POWER_UNIT_MODE);
  wire wr_ok   = sfr_wr & in_run;
  wire wr_smc  = wr_ok & sel_smc;
  wire wr_rs   = wr_ok & sel_rs;
  wire wr_pum  = wr_ok & sel_pum;

  wire [7:0] rd_smc = {vdm_en_ff, 1'b0, ~warn_low_s, warn_ie_ff, 4'h0};
  wire [7:0] rd_rs  = {1'b0, flag_flash_ff, 1'b0, flag_sw_ff, 2'h0, flag_por_ff, flag_pin_ff};
  wire [7:0] rd_pum = {2'h0, bat_mon_off_ff, 5'h00};
  wire [7:0] rd_mux = sel_smc ? rd_smc : sel_rs ? rd_rs : sel_pum ? rd_pum : 8'h00;

  // ****************************************************************
  // Reset sequencer
  // ****************************************************************
  // Battery loss overrides every state and restarts the power-on path
  always_comb begin
    nxt_state    = state_ff;
    nxt_dly_cnt  = dly_cnt_ff;
    nxt_hold_cnt = hold_cnt_ff;
    nxt_cause    = cause_ff;
    case (state_ff)
      ST_POR_WAIT: begin
        if (!bat_fail) begin
          nxt_state   = ST_POR_DELAY;
          nxt_dly_cnt = por_delay(vbat_lvl_s);
        end
      end
      ST_POR_DELAY: begin
        if (dly_cnt_ff == '0) begin
          nxt_state = ST_RUN;
        end else begin
          nxt_dly_cnt = dly_cnt_ff - 1'b1;
        end
      end
      ST_HOLD: begin
        nxt_cause = cause_ff | {2'h0, pin_ext_low, vdd_fail, 1'b0};
        if (hold_src) begin
          nxt_hold_cnt = RESET_HOLD_CYC;
        end else if (hold_cnt_ff == 4'h0) begin
          nxt_state = ST_RUN;
        end else begin
          nxt_hold_cnt = hold_cnt_ff - 1'b1;
        end
      end
      ST_RUN: begin
        if (any_src && bat_mon_off_ff) begin
          nxt_state   = ST_POR_DELAY;
          nxt_dly_cnt = por_delay(vbat_lvl_s);
          nxt_cause   = 5'h01;
        end else if (any_src) begin
          nxt_state    = ST_HOLD;
          nxt_hold_cnt = RESET_HOLD_CYC;
          nxt_cause    = {flash_err, sw_req_ff, pin_ext_low, vdd_fail, 1'b0};
        end
      end
      default: begin
        nxt_state = ST_POR_WAIT;
      end
    endcase
    if (bat_fail) begin
      nxt_state = ST_POR_WAIT;
      nxt_cause = 5'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_ff    <= ST_POR_WAIT;
      dly_cnt_ff  <= '0;
      hold_cnt_ff <= 4'h0;
      cause_ff    <= 5'h01;
      oe_hist_ff  <= 4'h0;
    end else begin
      state_ff    <= nxt_state;
      dly_cnt_ff  <= nxt_dly_cnt;
      hold_cnt_ff <= nxt_hold_cnt;
      cause_ff    <= nxt_cause;
      oe_hist_ff  <= {oe_hist_ff[2:0], rst_pin_oe_ff};
    end
  end

  // ****************************************************************
  // Cause flags, latched as reset ends
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      flag_pin_ff   <= 1'b0;
      flag_por_ff   <= 1'b1;
      flag_sw_ff    <= 1'b0;
      flag_flash_ff <= 1'b0;
    end else if (exit_rst) begin
      flag_pin_ff   <= cause_ff[C_PIN];
      flag_por_ff   <= cause_ff[C_POR] | cause_ff[C_VDD];
      flag_sw_ff    <= cause_ff[C_SW];
      flag_flash_ff <= cause_ff[C_FLASH];
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  // Enable and select survive soft resets; only power resets force them on
  always_ff @(posedge core_clk) begin
    if (reset) begin
      vdm_en_ff  <= 1'b1;
      vdm_sel_ff <= 1'b1;
    end else if (nxt_in_rst && full_por) begin
      vdm_en_ff  <= 1'b1;
      vdm_sel_ff <= 1'b1;
    end else begin
      if (wr_smc) begin
        vdm_en_ff <= sfr_wdata[SMC_ENABLE_BIT];
      end
      if (wr_rs) begin
        vdm_sel_ff <= sfr_wdata[RS_POR_BIT];
      end
    end
  end

  // Plain registers return to defaults on any reset
  always_ff @(posedge core_clk) begin
    if (reset || nxt_in_rst) begin
      warn_ie_ff     <= 1'b0;
      bat_mon_off_ff <= 1'b0;
      sw_req_ff      <= 1'b0;
    end else begin
      sw_req_ff <= wr_rs & sfr_wdata[RS_SW_BIT];
      if (wr_smc) begin
        warn_ie_ff <= sfr_wdata[SMC_WARN_IE_BIT];
      end
      if (wr_pum) begin
        bat_mon_off_ff <= sfr_wdata[PUM_MON_DIS_BIT];
      end
    end
  end

  // Read data lands one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sfr_rdata_ff <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata_ff <= rd_mux;
    end
  end

  // ****************************************************************
  // Reset outputs and pin control
  // ****************************************************************
  // RAM has no clear path here; stack pointer reload rides on sys_reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sys_reset_ff      <= 1'b1;
      rst_pin_out_ff    <= 1'b0;
      rst_pin_oe_ff     <= 1'b0;
      rst_pin_pullup_ff <= 1'b0;
    end else begin
      sys_reset_ff      <= nxt_in_rst;
      rst_pin_out_ff    <= 1'b0;
      rst_pin_oe_ff     <= nxt_in_rst & nxt_cause[C_VDD];
      rst_pin_pullup_ff <= ~(nxt_in_rst & nxt_cause[C_POR]);
    end
  end

  // Ports are held at their reset state for as long as the core is
  always_ff @(posedge core_clk) begin
    if (reset || nxt_in_rst) begin
      port_latch_ff      <= PORT_LATCH_RESET;
      port_open_drain_ff <= 1'b1;
    end else begin
      port_open_drain_ff <= 1'b0;
    end
  end

  // Release side: vector, clock choice and watchdog
  always_ff @(posedge core_clk) begin
    if (reset) begin
      port_pullup_ff <= 1'b1;
      clk_int_sel_ff <= 1'b1;
      wdt_en_ff      <= 1'b0;
      wdt_div_ff     <= WDT_CLK_DIV;
      fetch_start_ff <= 1'b0;
      fetch_addr_ff  <= RESET_VECTOR;
    end else begin
      port_pullup_ff <= 1'b1;
      clk_int_sel_ff <= nxt_in_rst | exit_rst;
      wdt_en_ff      <= ~nxt_in_rst;
      wdt_div_ff     <= WDT_CLK_DIV;
      fetch_start_ff <= exit_rst;
      fetch_addr_ff  <= RESET_VECTOR;
    end
  end

  // ****************************************************************
  // Supply and power-mode outputs
  // ****************************************************************
  // Warning interrupt is a level; it drops once supply recovers or is masked
  always_ff @(posedge core_clk) begin
    if (reset) begin
      regulator_en_ff    <= 1'b1;
      bat_mon_en_ff      <= 1'b1;
      vdd_mon_en_ff      <= 1'b1;
      supply_ok_ff       <= 1'b0;
      supply_warn_irq_ff <= 1'b0;
    end else begin
      regulator_en_ff    <= ~sleep_mode;
      bat_mon_en_ff      <= ~bat_mon_off_ff;
      vdd_mon_en_ff      <= vdm_en_ff & ~sleep_mode;
      supply_ok_ff       <= ~warn_low_s;
      supply_warn_irq_ff <= warn_ie_ff & warn_low_s;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_exit_por;
    !in_run && !nxt_in_rst && (cause_ff[C_POR] || cause_ff[C_VDD]);
  endsequence

  sequence s_exit_other;
    !in_run && !nxt_in_rst && !cause_ff[C_POR] && !cause_ff[C_VDD];
  endsequence

  sequence s_run_trip;
    in_run && any_src && !bat_fail;
  endsequence

  a_pin_forces_reset: assert property (in_run && pin_ext_low && !bat_fail |=> sys_reset_ff)
    else $error("pin low did not reset core");
  a_vdd_drives_pin: assert property (in_run && vdd_fail && !bat_fail && !bat_mon_off_ff
    |=> rst_pin_oe_ff && !rst_pin_out_ff && sys_reset_ff)
    else $error("supply fail did not drive pin");
  a_por_pin_float: assert property (state_ff == ST_POR_WAIT ##1 state_ff == ST_POR_WAIT
    |-> !rst_pin_oe_ff && !rst_pin_pullup_ff)
    else $error("pin not floating during power-on");
  a_por_delay_load: assert property (state_ff == ST_POR_WAIT && !bat_fail && vbat_lvl_s == 2'h0
    |=> state_ff == ST_POR_DELAY && dly_cnt_ff == DLY_W'(POR_CYC_LOW - 1))
    else $error("wrong power-on delay load");
  a_por_flag_set: assert property (s_exit_por |=> flag_por_ff && !sys_reset_ff)
    else $error("power-on flag not set");
  a_other_clear_por: assert property (s_exit_other |=> !flag_por_ff)
    else $error("power-on flag not cleared");
  a_pin_flag_exit: assert property (s_exit_other and cause_ff[C_PIN]
    |=> flag_pin_ff ##1 fetch_start_ff == 1'b0)
    else $error("pin flag not set");
  a_soft_keeps_mon: assert property (s_run_trip and (!bat_mon_off_ff && !vdd_fail && !sfr_wr)
    |=> $stable(vdm_en_ff) && $stable(vdm_sel_ff))
    else $error("soft reset changed monitor state");
  a_sleep_masks_pf: assert property (sleep_mode |-> !vdd_fail)
    else $error("power-fail not masked in sleep");
  a_flash_err_rst: assert property (in_run && flash_wr_attempt && !vdm_en_ff
    |=> sys_reset_ff && cause_ff[C_FLASH] != bat_mon_off_ff)
    else $error("flash error did not reset");
  a_hold_no_delay: assert property (state_ff == ST_HOLD && !hold_src && hold_cnt_ff == 4'h0
    && !bat_fail |=> in_run && fetch_start_ff)
    else $error("hold release was delayed");
  a_monoff_full_por: assert property (s_run_trip and bat_mon_off_ff
    |=> state_ff == ST_POR_DELAY && cause_ff == 5'h01 ##1 bat_mon_en_ff)
    else $error("monitor off did not give full power-on");
  a_warn_clears_ok: assert property (warn_low_s |=> !supply_ok_ff)
    else $error("supply ok not cleared");
  a_sleep_reg_off: assert property (sleep_mode |=> !regulator_en_ff)
    else $error("regulator on in sleep");
  a_ports_in_reset: assert property (sys_reset_ff |-> port_latch_ff == PORT_LATCH_RESET
    && port_open_drain_ff && port_pullup_ff)
    else $error("ports not in reset state");
  a_exit_vector: assert property (fetch_start_ff |-> fetch_addr_ff == RESET_VECTOR && wdt_en_ff
    && wdt_div_ff == WDT_CLK_DIV && clk_int_sel_ff)
    else $error("bad release state");

endmodule

// ---- logic/rsc_pkg.sv ----
package rsc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_SUPPLY_MON_CTRL = 8'hff;
  localparam logic [7:0] ADDR_RESET_SOURCE    = 8'hef;
  localparam logic [7:0] ADDR_POWER_UNIT_MODE = 8'hb5;

  // Supply monitor control fields
  localparam int SMC_ENABLE_BIT  = 7;
  localparam int SMC_OK_BIT      = 5;
  localparam int SMC_WARN_IE_BIT = 4;

  // Reset source register fields
  localparam int RS_PIN_BIT   = 0;
  localparam int RS_POR_BIT   = 1;
  localparam int RS_SW_BIT    = 4;
  localparam int RS_FLASH_BIT = 6;

  // Power unit mode register fields
  localparam int PUM_MON_DIS_BIT = 5;

  // ****************************************************************
  // Reset values and fixed figures
  // ****************************************************************
  localparam logic [7:0]  PORT_LATCH_RESET = 8'hff;
  localparam logic [15:0] RESET_VECTOR     = 16'h0000;
  localparam logic [3:0]  WDT_CLK_DIV      = 4'hc;
  localparam logic [3:0]  RESET_HOLD_CYC   = 4'h4;

  // Cause vector positions
  localparam int C_POR   = 0;
  localparam int C_VDD   = 1;
  localparam int C_PIN   = 2;
  localparam int C_SW    = 3;
  localparam int C_FLASH = 4;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned POR_DLY_LOW_US  = 3000;
  localparam int unsigned POR_DLY_MID_US  = 7000;
  localparam int unsigned POR_DLY_HIGH_US = 15000;
  localparam int unsigned POR_CYC_LOW     = POR_DLY_LOW_US * (CLK_HZ / 1_000_000);
  localparam int unsigned POR_CYC_MID     = POR_DLY_MID_US * (CLK_HZ / 1_000_000);
  localparam int unsigned POR_CYC_HIGH    = POR_DLY_HIGH_US * (CLK_HZ / 1_000_000);
  localparam int          DLY_W           = 20;

  typedef enum logic [3:0] {
    ST_POR_WAIT  = 4'b0001,
    ST_POR_DELAY = 4'b0010,
    ST_HOLD      = 4'b0100,
    ST_RUN       = 4'b1000
  } rst_state_t;

endpackage

// ---- logic/sync_if.sv ----
`timescale 1ns/10ps
// Raw pin levels in, filtered levels out
interface sync_if #(parameter int WIDTH = 1);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] clean;
  modport sync_side (input raw, output clean);
  modport user_side (output raw, input clean);
endinterface

// ---- tb/ext_reset_model.sv ----
`timescale 1ns/10ps
// ****************************************************************
// External reset pin circuitry with a board pull-up
// ****************************************************************
module ext_reset_model (
  input  wire logic pin_oe,
  input  wire logic pin_out,
  input  wire logic pull_low,
  output logic      pin_n
);
  // Wired level: any driver low wins, the pull-up gives high once all release
  assign pin_n = ((pin_oe & ~pin_out) | pull_low) ? 1'b0 : 1'b1;
endmodule

// ---- tb/reset_source_controller_tb.sv ----
`timescale 1ns/10ps
module reset_source_controller_tb;
  import rsc_pkg::*;
  logic        core_clk, reset, rst_pin_n, pull_low, vbat_low, vdd_below_rst, rd_q;
  logic        vdd_below_warn, sleep_mode, flash_wr_attempt, sfr_wr, sfr_rd, sys_reset_ff;
  logic        pin_out, pin_oe, pin_pu, port_od, port_pu, clk_int, wdt_en, fetch_start;
  logic        reg_en, bat_mon_en, vdd_mon_en, supply_ok, warn_irq;
  logic [1:0]  vbat_level;
  logic [3:0]  wdt_div;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata_ff, port_latch;
  logic [15:0] fetch_addr;
  logic [7:0]  exp_q[$];
  int          err_count, checked, seed, dly, n;

  // ****************************************************************
  // Clock, design and far side
  // ****************************************************************
  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;

  // Short delay figures keep the power-on waits to a few dozen cycles
  reset_source_controller #(.POR_CYC_LOW(20), .POR_CYC_MID(30), .POR_CYC_HIGH(40)) dut_u (
    .core_clk(core_clk), .reset(reset), .rst_pin_n_in(rst_pin_n), .vbat_low(vbat_low),
    .vbat_level(vbat_level), .vdd_below_rst(vdd_below_rst), .vdd_below_warn(vdd_below_warn),
    .sleep_mode(sleep_mode), .flash_wr_attempt(flash_wr_attempt), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_ff(sfr_rdata_ff),
    .sys_reset_ff(sys_reset_ff), .rst_pin_out_ff(pin_out), .rst_pin_oe_ff(pin_oe),
    .rst_pin_pullup_ff(pin_pu), .port_latch_ff(port_latch), .port_open_drain_ff(port_od),
    .port_pullup_ff(port_pu), .clk_int_sel_ff(clk_int), .wdt_en_ff(wdt_en),
    .wdt_div_ff(wdt_div), .fetch_start_ff(fetch_start), .fetch_addr_ff(fetch_addr),
    .regulator_en_ff(reg_en), .bat_mon_en_ff(bat_mon_en), .vdd_mon_en_ff(vdd_mon_en),
    .supply_ok_ff(supply_ok), .supply_warn_irq_ff(warn_irq));

  ext_reset_model ext_u (.pin_oe(pin_oe), .pin_out(pin_out), .pull_low(pull_low),
    .pin_n(rst_pin_n));

  // ****************************************************************
  // Checking
  // ****************************************************************
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Read data lands one edge after the strobe, so compare at the next falling edge
  always @(posedge core_clk) rd_q <= sfr_rd;
  always @(negedge core_clk) begin
    if (rd_q === 1'b1) begin
      if (exp_q.size() == 0) chk("read_extra", 32'h0, 32'h1);
      else chk("sfr_rdata", {24'h0, exp_q.pop_front()}, {24'h0, sfr_rdata_ff});
    end
  end

  task automatic summarize();
    if (err_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // Register and reset helpers
  // ****************************************************************
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge core_clk);
    sfr_wr = 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] e);
    exp_q.push_back(e);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge core_clk);
    sfr_rd = 1'b0;
  endtask

  // Let the reset start, then wait a bounded time for release and check the exit state;
  // the fetch pulse rises on the same edge that drops the core reset
  task automatic wait_run(int lim);
    repeat (3) @(negedge core_clk);
    n = 0;
    while (sys_reset_ff !== 1'b0 && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    chk("release", 32'h0, sys_reset_ff);
    chk("fetch_start", 32'h1, fetch_start);
    chk("exit", {1'b1, 4'hc, 16'h0000}, {wdt_en, wdt_div, fetch_addr});
    @(negedge core_clk);
    chk("fetch_pulse", 32'h0, fetch_start);
  endtask

  task automatic in_rst();
    chk("in_reset", {8'hff, 4'b1101}, {port_latch, port_od, clk_int, wdt_en, port_pu});
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    seed = 32'h98b236c7;
    {pull_low, vdd_below_rst, vdd_below_warn, sleep_mode, flash_wr_attempt} = '0;
    {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = '0;
    vbat_level = 2'($random(seed));
    vbat_low = 1'b1;
    reset = 1'b1;
    repeat (12) @(negedge core_clk);
    reset = 1'b0;
    repeat (10) @(negedge core_clk);
    chk("por_pin", 32'h0, {pin_oe, pin_pu});
    in_rst();
    vbat_low = 1'b0;
    dly = (vbat_level == 2'd0) ? 20 : (vbat_level == 2'd1) ? 30 : 40;
    wait_run(200);
    chk("por_delay", 32'h1, (n >= dly - 3) && (n <= dly + 10));
    rd(8'hef, 8'h02);
    rd(8'hff, 8'ha0);
    wr(8'h33, 8'($random(seed)));
    rd(8'h33, 8'h00);
    // Early warning with its interrupt enabled
    wr(8'hff, 8'h90);
    vdd_below_warn = 1'b1;
    repeat (8) @(negedge core_clk);
    chk("warn", 32'h1, {supply_ok, warn_irq});
    rd(8'hff, 8'h90);
    vdd_below_warn = 1'b0;
    // Core supply failure drives the pin and skips the power-on delay
    vdd_below_rst = 1'b1;
    repeat (8) @(negedge core_clk);
    chk("vdd_reset", 32'h6, {sys_reset_ff, pin_oe, pin_out});
    vdd_below_rst = 1'b0;
    wait_run(20);
    chk("vdd_delay", 32'h1, n < 15);
    rd(8'hef, 8'h02);
    rd(8'hff, 8'ha0);
    // External pin reset
    pull_low = 1'b1;
    repeat (8) @(negedge core_clk);
    chk("pin_reset", 32'h5, {sys_reset_ff, pin_oe, pin_pu});
    in_rst();
    pull_low = 1'b0;
    wait_run(30);
    rd(8'hef, 8'h01);
    // Software reset keeps a disabled, deselected monitor
    wr(8'hff, 8'h00);
    wr(8'hef, 8'h10);
    wait_run(20);
    rd(8'hef, 8'h10);
    rd(8'hff, 8'h20);
    // Flash write while the monitor is off
    @(negedge core_clk);
    flash_wr_attempt = 1'b1;
    @(negedge core_clk);
    flash_wr_attempt = 1'b0;
    wait_run(20);
    rd(8'hef, 8'h40);
    wr(8'hff, 8'h80);
    repeat (4) @(negedge core_clk);
    wr(8'hef, 8'h02);
    // Sleep masks supply failure and stops the regulator
    sleep_mode = 1'b1;
    vdd_below_rst = 1'b1;
    repeat (10) @(negedge core_clk);
    chk("sleep", 32'h0, {sys_reset_ff, reg_en, vdd_mon_en});
    vdd_below_rst = 1'b0;
    repeat (6) @(negedge core_clk);
    sleep_mode = 1'b0;
    repeat (3) @(negedge core_clk);
    chk("wake", 32'h3, {sys_reset_ff, reg_en, vdd_mon_en});
    // Battery monitor off turns the next reset into a full power-on reset
    wr(8'hb5, 8'h20);
    repeat (2) @(negedge core_clk);
    chk("mon_off", 32'h0, bat_mon_en);
    wr(8'hef, 8'h12);
    wait_run(200);
    chk("mon_on", 32'h1, bat_mon_en);
    rd(8'hef, 8'h02);
    repeat (4) @(negedge core_clk);
    summarize();
  end

  // Hang guard well beyond the few hundred cycles the scenarios need
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    summarize();
  end
endmodule
